// ---- rtl/bus_term_params.svh ----
// Constants for the processor bus cycle termination block
// Notes on behaviour
// - Cache hit aborts prefetch cycle, no address strobe
// - Cycle start only while bus idle
// - Prefetch at most every other clock
// - Aborted cycles hidden while bus busy
// - Address strobe starts cycle, data strobe qualifies
// - No limit on wait for acknowledge
// - Acknowledged cycle takes at least three clocks
// - Input recognized two clocks after its sampling edge
// - Read data latched edge after ack
// - Ack at state 2 end gives three clocks
// - Strobe/ack handshake, or bus error alone, governs transfers
`ifndef BUS_TERM_PARAMS_SVH
`define BUS_TERM_PARAMS_SVH
`define ACK_NONE  2'b00
`define ACK_BYTE  2'b01
`define ACK_WORD  2'b10
`define ACK_LONG  2'b11
`define PREFETCH_GAP 2'h2
`endif

// ---- rtl/bus_term_pkg.sv ----
// Types for the processor bus cycle termination block
package bus_term_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WAIT  = 3'b011,
    ST_LATCH = 3'b010,
    ST_END   = 3'b110
  } bus_state_t;

  typedef enum logic [1:0]
  {
    PORT_NONE = 2'b00,
    PORT_8    = 2'b01,
    PORT_16   = 2'b10,
    PORT_32   = 2'b11
  } port_width_t;

  typedef enum logic [1:0]
  {
    END_OK    = 2'b00,
    END_ERROR = 2'b01,
    END_RETRY = 2'b10
  } cycle_end_t;

  typedef struct packed
  {
    logic        write;
    logic        instr;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed
  {
    cycle_end_t  kind;
    port_width_t width;
    logic [31:0] rdata;
  } bus_rsp_t;
endpackage

// ---- rtl/bus_term.sv ----
// Processor side external bus cycle sequencer with termination handshake
`timescale 1ns/1ps
`default_nettype none
`include "bus_term_params.svh"
module bus_term
  import bus_term_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Core request side
  input  wire logic        req_valid,
  input  wire bus_req_t    req,
  input  wire logic        cache_hit,
  output logic             req_ready,
  output logic             rsp_valid,
  output bus_rsp_t         rsp,
  // External bus
  output logic             ext_cycle_start,
  output logic             operand_cycle_start,
  output logic             addr_strobe_n,
  output logic             data_strobe_n,
  output logic [31:0]      addr_out,
  output logic             xfer_size_hi,
  output logic             xfer_size_lo,
  output logic             read_write,
  output logic [DATA_W-1:0] data_out,
  output logic             data_oe_n,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic        port_ack_hi,
  input  wire logic        port_ack_lo,
  input  wire logic        bus_error_in,
  input  wire logic        halt_in
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [DATA_W-1:0] din1_r;
  logic [DATA_W-1:0] din2_r;

  // Levels are recognized two edges after the edge that samples them
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end
    else
    begin
      sync1_r <= {port_ack_hi, port_ack_lo, bus_error_in, halt_in};
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    din1_r <= data_in;
    din2_r <= din1_r;
  end

  logic [1:0] ack_pair;
  logic       bus_error_in_s;
  logic       halt_s;
  assign ack_pair = sync2_r[3:2];
  assign bus_error_in_s   = sync2_r[1];
  assign halt_s   = sync2_r[0];

  function automatic port_width_t decode_ack(input logic [1:0] a);
    case (a)
      `ACK_BYTE: decode_ack = PORT_8;
      `ACK_WORD: decode_ack = PORT_16;
      `ACK_LONG: decode_ack = PORT_32;
      default:   decode_ack = PORT_NONE;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Cycle state machine
  // ------------------------------------------------------------
  bus_state_t  state_r;
  bus_req_t    cur_r;
  port_width_t width_r;
  logic [1:0]  gap_r;
  logic        late_r;

  // Prefetch may start only when gap has expired
  logic start_ok;
  assign start_ok = req_valid && (state_r == ST_IDLE) &&
                    !(req.instr && gap_r != 2'h0);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      gap_r <= 2'h0;
    else if (start_ok && req.instr)
      gap_r <= `PREFETCH_GAP - 2'h1;
    else if (gap_r != 2'h0)
      gap_r <= gap_r - 2'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cur_r   <= '0;
      width_r <= PORT_NONE;
      late_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          // Start only when no other cycle holds the bus
          if (start_ok)
          begin
            cur_r   <= req;
            state_r <= ST_ADDR;
          end
        ST_ADDR:
          // Hit aborts before address strobe; hidden if never started
          if (cur_r.instr && cache_hit)
            state_r <= ST_IDLE;
          else
            state_r <= ST_WAIT;
        ST_WAIT:
          // Unbounded whole-clock waits until ack or error
          if (ack_pair != `ACK_NONE || bus_error_in_s)
          begin
            width_r <= decode_ack(ack_pair);
            late_r  <= bus_error_in_s;
            state_r <= ST_LATCH;
          end
        ST_LATCH:
        begin
          // Late error sampled one clock after ack
          late_r  <= late_r | bus_error_in_s;
          state_r <= ST_END;
        end
        ST_END:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Bus pins
  // ------------------------------------------------------------
  logic strobe_on;
  assign strobe_on = (state_r == ST_WAIT) || (state_r == ST_LATCH);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ext_cycle_start     <= 1'b0;
      operand_cycle_start <= 1'b0;
      addr_strobe_n       <= 1'b1;
      data_strobe_n       <= 1'b1;
      addr_out            <= 32'h0000_0000;
      xfer_size_hi        <= 1'b0;
      xfer_size_lo        <= 1'b0;
      read_write          <= 1'b1;
      data_out            <= '0;
      data_oe_n           <= 1'b1;
    end
    else
    begin
      ext_cycle_start     <= start_ok;
      operand_cycle_start <= start_ok && !req.instr;
      // Address strobe marks the cycle; data strobe qualifies write data
      addr_strobe_n       <= !(strobe_on || (state_r == ST_ADDR &&
                               !(cur_r.instr && cache_hit)));
      data_strobe_n       <= !strobe_on;
      if (start_ok)
      begin
        addr_out     <= req.addr;
        xfer_size_hi <= req.size[1];
        xfer_size_lo <= req.size[0];
        read_write   <= !req.write;
        data_out     <= req.wdata[DATA_W-1:0];
      end
      data_oe_n <= !(cur_r.write && (state_r != ST_IDLE));
    end
  end

  // ------------------------------------------------------------
  // Response
  // ------------------------------------------------------------
  // Cycle spans ADDR, WAIT, LATCH, END: four clocks minimum
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
      req_ready <= 1'b0;
    end
    else
    begin
      req_ready <= start_ok;
      rsp_valid <= (state_r == ST_END) ||
                   (state_r == ST_ADDR && cur_r.instr && cache_hit);
      if (state_r == ST_LATCH)
        // Data latched the edge after ack; width from ack pair
        rsp.rdata <= din2_r[31:0];
      // Hit abort answers at once: plain end, no port width
      if (state_r == ST_ADDR && cur_r.instr && cache_hit)
      begin
        rsp.width <= PORT_NONE;
        rsp.kind  <= END_OK;
      end
      if (state_r == ST_END)
      begin
        rsp.width <= width_r;
        // Error alone aborts, error with halt retries
        if (late_r)
          rsp.kind <= halt_s ? END_RETRY : END_ERROR;
        else
          rsp.kind <= END_OK;
      end
    end
  end

endmodule
`default_nettype wire

// ---- sim/bus_term_properties.sv ----
// Checker for the bus cycle termination block
`timescale 1ns/1ps
`default_nettype none
module bus_term_properties
  import bus_term_pkg::*;
(
  // Watched ports
  input wire logic     core_clk,
  input wire logic     rst_n,
  input wire logic     rsp_valid,
  input wire bus_rsp_t rsp,
  input wire logic     ext_cycle_start,
  input wire logic     operand_cycle_start,
  input wire logic     addr_strobe_n,
  input wire logic     data_strobe_n,
  input wire logic     read_write,
  input wire logic     data_oe_n,
  input wire logic     port_ack_hi,
  input wire logic     port_ack_lo,
  input wire logic     bus_error_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_strobe_after_start: assert property ($fell(addr_strobe_n) |-> $past(ext_cycle_start))
    else $error("strobe without start");
  a_cycle_min_len: assert property ($fell(addr_strobe_n) |-> !addr_strobe_n [*3])
    else $error("cycle too short");
  a_start_bus_idle: assert property (ext_cycle_start |-> addr_strobe_n)
    else $error("start while busy");
  a_operand_with_ext: assert property (operand_cycle_start |-> ext_cycle_start)
    else $error("operand start alone");
  a_prefetch_gap: assert property (ext_cycle_start && !operand_cycle_start
    |=> !(ext_cycle_start && !operand_cycle_start)) else $error("prefetch too close");
  a_wait_no_limit: assert property ((!addr_strobe_n && !port_ack_hi && !port_ack_lo
    && !bus_error_in) [*3] |=> !addr_strobe_n) else $error("cycle ended without ack");
  a_write_drives_data: assert property (!data_strobe_n && !read_write |-> !data_oe_n)
    else $error("write data not driven");
  a_hit_no_strobe: assert property (rsp_valid && rsp.kind == END_OK && rsp.width == PORT_NONE
    |-> addr_strobe_n && $past(addr_strobe_n) && $past(addr_strobe_n, 2))
    else $error("strobe on hit abort");
endmodule
bind bus_term bus_term_properties bus_term_properties_i (.core_clk, .rst_n, .rsp_valid, .rsp,
  .ext_cycle_start, .operand_cycle_start, .addr_strobe_n, .data_strobe_n, .read_write,
  .data_oe_n, .port_ack_hi, .port_ack_lo, .bus_error_in);
`default_nettype wire

// ---- sim/bus_slave_model.sv ----
// Slave model answering the external bus handshake
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model
(
  // Bus from the block
  input  wire logic        core_clk,
  input  wire logic        addr_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic        read_write,
  input  wire logic [31:0] addr_out,
  input  wire logic [31:0] data_out,
  // Scenario controls
  input  wire logic [1:0]  width,
  input  wire logic [1:0]  fault,
  input  wire logic [4:0]  delay,
  // Answers
  output logic [31:0]      data_in = 32'h0,
  output logic             port_ack_hi = 1'h0,
  output logic             port_ack_lo = 1'h0,
  output logic             bus_error_in = 1'h0,
  output logic             halt_in = 1'h0,
  output logic [31:0]      wr_seen = 32'h0
);
  int n = 0;
  // Answers in step with the processor clock
  always @(negedge core_clk)
    if (addr_strobe_n)
    begin
      n <= 0;
      {port_ack_hi, port_ack_lo, bus_error_in, halt_in} <= 4'h0;
      data_in <= ~data_in;
    end
    else
    begin
      n <= n + 1;
      if (!data_strobe_n && !read_write) wr_seen <= data_out;
      if (n == delay)
      begin
        if (fault == 2'h0 || fault == 2'h3) {port_ack_hi, port_ack_lo} <= width;
        else {bus_error_in, halt_in} <= {1'h1, fault == 2'h2};
        // Read data ignores the low address bits and the size
        data_in <= {addr_out[31:2], 2'h0} ^ 32'h5A5A0000;
      end
      // Late error one clock after the acknowledge
      if (fault == 2'h3 && n == delay + 1) bus_error_in <= 1'h1;
    end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the bus cycle termination block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bus_term_pkg::*;
  logic core_clk = 0, rst_n = 0, req_valid = 0, cache_hit = 0;
  logic req_ready, rsp_valid, ext_cycle_start, operand_cycle_start;
  logic addr_strobe_n, data_strobe_n, read_write, data_oe_n;
  logic port_ack_hi, port_ack_lo, bus_error_in, halt_in, xfer_size_hi, xfer_size_lo;
  cycle_end_t exp_q[$];
  logic [31:0] addr_out, data_out, data_in, wr_seen, seed = 32'h0000AA6C;
  logic [1:0] width = 2'h3, fault = 2'h0;
  logic [4:0] delay = 5'h0;
  bus_req_t req = '0;
  bus_rsp_t rsp;
  int fails = 0, comparisons = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  bus_term bus_term_i (.core_clk, .rst_n, .req_valid, .req, .cache_hit, .req_ready, .rsp_valid,
    .rsp, .ext_cycle_start, .operand_cycle_start, .addr_strobe_n, .data_strobe_n, .addr_out,
    .xfer_size_hi, .xfer_size_lo, .read_write, .data_out, .data_oe_n, .data_in,
    .port_ack_hi, .port_ack_lo, .bus_error_in, .halt_in);
  bus_slave_model bus_slave_model_i (.core_clk, .addr_strobe_n, .data_strobe_n, .read_write,
    .addr_out, .data_out, .width, .fault, .delay, .data_in, .port_ack_hi, .port_ack_lo,
    .bus_error_in, .halt_in, .wr_seen);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One request, answered by the slave as set up, then compared
  task automatic run(logic w, logic ins, logic hit, logic [1:0] pw, logic [1:0] f,
                     cycle_end_t k, logic [4:0] d);
    logic [31:0] a;
    int n;
    a = rnd() & 32'hFFFFFFFC;
    n = 0;
    @(negedge core_clk);
    req = '{w, ins, a, 2'(rnd()), rnd()};
    {req_valid, cache_hit, width, fault, delay} = {1'h1, hit, pw, f, d};
    exp_q.push_back(k);
    while (req_ready !== 1'h1 && n < 50) begin @(posedge core_clk); #1 n++; end
    chk("req_ready", 32'h1, 32'(req_ready));
    chk("addr", a, addr_out);
    chk("size", 32'(req.size), 32'({xfer_size_hi, xfer_size_lo}));
    @(negedge core_clk) req_valid = 0;
    while (rsp_valid !== 1'h1 && n < 400) begin @(posedge core_clk); #1 n++; end
    chk("rsp_valid", 32'h1, 32'(rsp_valid));
    chk("cycles", hit ? 32'h2 : 32'(7 + d), 32'(n));
    chk("kind", 32'(exp_q.pop_front()), 32'(rsp.kind));
    if (k == END_OK) chk("width", hit ? 32'h0 : 32'(pw), 32'(rsp.width));
    if (!w && !hit && k == END_OK) chk("rdata", a ^ 32'h5A5A0000, rsp.rdata);
    if (w && k == END_OK) chk("wdata", req.wdata, wr_seen);
    $display("test done w %0d hit %0d width %0d fault %0d", w, hit, pw, f);
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1;
    for (int i = 0; i < 12; i++)
      run(rnd() % 2 == 1, 0, 0, 2'(i % 3 + 1), 0, END_OK, 5'(rnd() % 4));
    run(0, 0, 0, 2'h3, 0, END_OK, 5'h19);
    run(0, 0, 0, 2'h3, 2'h1, END_ERROR, 5'h2);
    run(1, 0, 0, 2'h3, 2'h2, END_RETRY, 5'h0);
    run(0, 0, 0, 2'h3, 2'h3, END_ERROR, 5'h1);
    run(0, 1, 1, 2'h3, 0, END_OK, 5'h0);
    run(0, 0, 0, 2'h3, 0, END_OK, 5'h0);
    run(0, 1, 0, 2'h3, 0, END_OK, 5'h1);
    run(0, 1, 1, 2'h3, 0, END_OK, 5'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
